// File: verilog/ecg_status_pkg.sv
// Purpose: constants for the status and switch-control register pair
// Assumes: 8-bit register addresses, 24-bit register data
// Notes: shared by the register bank and its config-load sequencer
package ecg_status_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h1e;
  localparam logic [7:0] ADDR_SWITCH = 8'h1f;
  localparam int DATA_W = 24;
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  localparam logic [23:0] SWITCH_RESET = 24'h000000;
  localparam int BIT_DIGITAL_FAULT = 3;
  localparam int BIT_CFG_PENDING = 2;
  localparam int BIT_LOCK_LOST = 1;
  localparam int BIT_PLL_LOCKED = 0;
  localparam int RESP_RA_MSB = 23;
  localparam int RESP_LL_MSB = 18;
  localparam int RESP_LA_MSB = 13;
  localparam int RESP_GROUP_W = 5;
  localparam int BIT_CHEST1_AUX = 8;
  localparam int BIT_CHEST2_AUX = 7;
  localparam int SWITCH_RW_LSB = 7;
  localparam int CFG_LOAD_CYCLES = 16;
endpackage : ecg_status_pkg

// File: verilog/cfg_load_timer.sv
// Purpose: holds the configuration-pending level until the load finishes
// Assumes: rst synchronous active high
// Notes: done rises after LOAD_CYCLES clocks and then stays
`timescale 1ns/1ps
module cfg_load_timer #(
  parameter int LOAD_CYCLES = ecg_status_pkg::CFG_LOAD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic done
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (!done_r) begin
      if (cnt_r == 16'(LOAD_CYCLES - 1)) begin
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule : cfg_load_timer

// File: verilog/ecg_frontend_status_switch_regs.sv
// Purpose: status word and respiration/aux switch control registers
// Assumes: core-clock register port driven by the serial command decoder
// Notes: neither register feeds the streamed frame; read only by command
`timescale 1ns/1ps
module ecg_frontend_status_switch_regs #(
  parameter int LOAD_CYCLES = ecg_status_pkg::CFG_LOAD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic core_error,
  input wire logic pll_lock_pin,
  input wire logic power_enable_bit,
  output logic [4:0] resp_input_right_arm,
  output logic [4:0] resp_input_left_leg,
  output logic [4:0] resp_input_left_arm,
  output logic chest1_aux_reference_sel,
  output logic chest2_aux_reference_sel
);
  logic lock_s1_r;
  logic lock_s2_r;
  logic err_s1_r;
  logic err_s2_r;
  logic fault_r;
  logic fault_nxt;
  logic was_locked_r;
  logic was_locked_nxt;
  logic lost_r;
  logic lost_nxt;
  logic [23:0] sw_r;
  logic [23:0] sw_nxt;
  logic [23:0] rdata_r;
  logic [23:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic cfg_done;
  logic [23:0] status_word;
  logic rd_status;

  cfg_load_timer #(.LOAD_CYCLES(LOAD_CYCLES)) u_cfg (
    .clk(clk),
    .rst(rst),
    .done(cfg_done)
  );

  // pin-level inputs pass two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      err_s1_r <= 1'b0;
      err_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= pll_lock_pin;
      lock_s2_r <= lock_s1_r;
      err_s1_r <= core_error;
      err_s2_r <= err_s1_r;
    end
  end

  assign rd_status = reg_rd && (reg_addr == ecg_status_pkg::ADDR_STATUS);

  always_comb begin
    status_word = ecg_status_pkg::STATUS_RESET;
    status_word[ecg_status_pkg::BIT_DIGITAL_FAULT] = fault_r;
    status_word[ecg_status_pkg::BIT_CFG_PENDING] = ~cfg_done;
    status_word[ecg_status_pkg::BIT_LOCK_LOST] = lost_r;
    status_word[ecg_status_pkg::BIT_PLL_LOCKED] = lock_s2_r;
  end

  always_comb begin
    fault_nxt = fault_r | err_s2_r;
    was_locked_nxt = was_locked_r;
    lost_nxt = lost_r;
    if (!power_enable_bit) begin
      was_locked_nxt = 1'b0;
    end else if (lock_s2_r) begin
      was_locked_nxt = 1'b1;
    end else if (was_locked_r) begin
      // a loss is taken once, so a read can clear the flag while still unlocked
      was_locked_nxt = 1'b0;
    end
    // the read captures the old value, the clear lands after it; a new loss wins
    if (rd_status || !power_enable_bit) begin
      lost_nxt = 1'b0;
    end
    if (power_enable_bit && was_locked_r && !lock_s2_r) begin
      lost_nxt = 1'b1;
    end
  end

  always_comb begin
    sw_nxt = sw_r;
    if (reg_wr && (reg_addr == ecg_status_pkg::ADDR_SWITCH)) begin
      sw_nxt = ecg_status_pkg::SWITCH_RESET;
      sw_nxt[23:ecg_status_pkg::SWITCH_RW_LSB] = reg_wdata[23:ecg_status_pkg::SWITCH_RW_LSB];
    end
  end

  // only explicit reads return these words; nothing here feeds a frame
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ecg_status_pkg::ADDR_STATUS: rdata_nxt = status_word;
        ecg_status_pkg::ADDR_SWITCH: rdata_nxt = sw_r;
        default: rdata_nxt = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
      was_locked_r <= 1'b0;
      lost_r <= 1'b0;
      sw_r <= ecg_status_pkg::SWITCH_RESET;
      rdata_r <= 24'h000000;
      rvalid_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      was_locked_r <= was_locked_nxt;
      lost_r <= lost_nxt;
      sw_r <= sw_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign resp_input_right_arm = sw_r[ecg_status_pkg::RESP_RA_MSB -: ecg_status_pkg::RESP_GROUP_W];
  assign resp_input_left_leg = sw_r[ecg_status_pkg::RESP_LL_MSB -: ecg_status_pkg::RESP_GROUP_W];
  assign resp_input_left_arm = sw_r[ecg_status_pkg::RESP_LA_MSB -: ecg_status_pkg::RESP_GROUP_W];
  assign chest1_aux_reference_sel = sw_r[ecg_status_pkg::BIT_CHEST1_AUX];
  assign chest2_aux_reference_sel = sw_r[ecg_status_pkg::BIT_CHEST2_AUX];
endmodule : ecg_frontend_status_switch_regs

// File: dv/regs_checker_assertions.sv
// Purpose: port checks for status and switch registers
// Assumes: one clock, rst synchronous active high
// Notes: bound from tb
`timescale 1ns/1ps
module regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pll_lock_pin,
  input wire logic core_error,
  input wire logic power_enable_bit,
  input wire logic [4:0] resp_input_right_arm,
  input wire logic [4:0] resp_input_left_leg,
  input wire logic [4:0] resp_input_left_arm,
  input wire logic chest1_aux_reference_sel,
  input wire logic chest2_aux_reference_sel
);
  logic [16:0] sw;
  assign sw = {resp_input_right_arm, resp_input_left_leg, resp_input_left_arm,
    chest1_aux_reference_sel, chest2_aux_reference_sel};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence lock_steady;
    $stable(pll_lock_pin) [*4];
  endsequence
  sequence status_read;
    reg_rd && reg_addr == 8'h1e;
  endsequence
  sequence error_held;
    core_error [*4];
  endsequence
  // lock seen through the synchroniser, then lost with no status read in between
  sequence locked_then_lost;
    (power_enable_bit && pll_lock_pin) [*4] ##1 (power_enable_bit && !pll_lock_pin && !reg_rd) [*5];
  endsequence
  AST_RV_PULSE: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
  AST_RV_IDLE: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
  AST_SW_WRITE: assert property (reg_wr && reg_addr == 8'h1f |=> sw == $past(reg_wdata[23:7])) else $error("sw");
  AST_SW_HOLD: assert property (!reg_wr |=> $stable(sw)) else $error("sw moved");
  AST_SW_READ: assert property (reg_rd && !reg_wr && reg_addr == 8'h1f |=> reg_rdata == {$past(sw), 7'h00})
    else $error("sw read");
  AST_ST_HIGH: assert property (reg_rd && reg_addr == 8'h1e |=> reg_rdata[23:4] == 20'h00000) else $error("hi");
  AST_UNMAPPED: assert property (reg_rd && reg_addr[7:1] != 7'h0f |=> reg_rdata == 24'h000000) else $error("unmap");
  AST_LIVE_LOCK: assert property (lock_steady ##0 status_read |=> reg_rdata[0] == $past(pll_lock_pin))
    else $error("lock");
  AST_FAULT_SET: assert property (error_held ##0 status_read |=> reg_rdata[3] == 1'b1) else $error("fault");
  AST_LOST_SET: assert property (locked_then_lost ##1 (power_enable_bit && !pll_lock_pin) ##0 status_read |=>
    reg_rdata[1] == 1'b1) else $error("lost");
  AST_PE_CLEAR: assert property (!power_enable_bit ##1 !power_enable_bit ##0 status_read |=>
    reg_rdata[1] == 1'b0) else $error("pe clear");
endmodule : regs_checker

// File: dv/host_model.sv
// Purpose: host issuing register commands
// Assumes: requests driven 1 ns after the edge
// Notes: idle address and data lines show the inverse of the last value; reg_rd and reg_wr drop to 0
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata
);
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 34'h0;
  task automatic cmd(input logic wr, input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {!wr, wr, a, d};
    @(posedge clk);
    #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask : cmd
endmodule : host_model

// File: dv/tb.sv
// Purpose: register-level test of status and switch registers
// Assumes: LOAD_CYCLES set to 4
// Notes: inputs change 1 ns after the edge
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic core_error = 1'b0;
  logic pll_lock_pin = 1'b0;
  logic power_enable_bit = 1'b0;
  logic reg_rd, reg_wr, reg_rvalid, chest1_aux_reference_sel, chest2_aux_reference_sel;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [4:0] resp_input_right_arm, resp_input_left_leg, resp_input_left_arm;
  int bad_count = 0;
  int check_count = 0;
  wire [23:0] sw = {7'h00, resp_input_right_arm, resp_input_left_leg, resp_input_left_arm,
    chest1_aux_reference_sel, chest2_aux_reference_sel};
  always #10 clk = ~clk;
  host_model i_host (.*);
  ecg_frontend_status_switch_regs #(.LOAD_CYCLES(4)) i_dut (.*);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    i_host.cmd(1'b0, a, 24'h000000);
    chk(reg_rvalid ? reg_rdata : 24'hxxxxxx, exp);
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    wait_n(6);
    rst = 1'b0;
    rd(8'h1e, 24'h000004);
    rd(8'h1f, 24'h000000);
    wait_n(6);
    rd(8'h1e, 24'h000000);
    {power_enable_bit, pll_lock_pin} = 2'b11;
    wait_n(4);
    rd(8'h1e, 24'h000001);
    pll_lock_pin = 1'b0;
    wait_n(4);
    rd(8'h1e, 24'h000002);
    rd(8'h1e, 24'h000000);
    pll_lock_pin = 1'b1;
    wait_n(4);
    pll_lock_pin = 1'b0;
    wait_n(4);
    power_enable_bit = 1'b0;
    wait_n(2);
    rd(8'h1e, 24'h000000);
    core_error = 1'b1;
    wait_n(5);
    rd(8'h1e, 24'h000008);
    i_host.cmd(1'b1, 8'h1f, 24'hffffff);
    chk(sw, 24'h01ffff);
    rd(8'h1f, 24'hffff80);
    i_host.cmd(1'b1, 8'h1f, 24'h800080);
    chk(sw, 24'h010001);
    i_host.cmd(1'b1, 8'h1e, 24'hffffff);
    rd(8'h1e, 24'h000008);
    rd(8'h20, 24'h000000);
    summarize();
  end
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule : tb
bind ecg_frontend_status_switch_regs regs_checker i_chk (.*);
